// File: verilog/spindle_regs.svh
`ifndef SPINDLE_REGS_SVH
`define SPINDLE_REGS_SVH
// ------------------------------------------------------------
// Register offsets (byte address, one word each)
// ------------------------------------------------------------
`define OFS_ANALOG_STATUS  8'h00
`define OFS_SERIAL_STATUS  8'h04
`define OFS_SELECT_CTRL    8'h08
`define OFS_CONFIG         8'h0c
`define OFS_GEAR_MAX0      8'h10
`define OFS_GEAR_MAX1      8'h14
`define OFS_GEAR_MAX2      8'h18
`define OFS_GEAR_MAX3      8'h1c
`define OFS_SPEED_CMD      8'h20
`define OFS_EXT_CODE       8'h24
`define OFS_SPEED_OUT1     8'h28
`define OFS_SPEED_OUT2     8'h2c
`define OFS_GEAR_STATUS    8'h30
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_ANALOG_FLAG    0
`define BIT_SERIAL_ONE     0
`define BIT_SERIAL_TWO     1
`define BIT_SERIAL_THREE   2
`define BIT_SPINDLE_ONE    0
`define BIT_SPINDLE_TWO    1
`define BIT_SCHEME         0
`define BIT_ARR_LO         1
`define BIT_ARR_HI         2
`define BIT_SRC_SEL        3
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_SELECT_CTRL    8'h00
`define RST_CONFIG         8'h00
`define RST_GEAR_MAX       16'h0000
`define RST_SPEED          12'h000
`endif

// File: verilog/spindle_pkg.sv
package spindle_pkg;
    // Spindle control arrangement
    typedef enum logic [1:0] {
        ARR_MECHANICAL = 2'b00,
        ARR_ANALOG     = 2'b01,
        ARR_SERIAL     = 2'b11,
        ARR_DUAL       = 2'b10
    } arrangement_t;

    // Gear handshake states, Gray from idle to output; the return to idle flips both bits
    typedef enum logic [1:0] {
        G_IDLE   = 2'b00,
        G_SELECT = 2'b01,
        G_OUTPUT = 2'b11
    } gear_state_t;

    // Per-spindle user controls
    typedef struct packed {
        logic stop;
        logic enable;
    } spindle_ctl_t;
endpackage : spindle_pkg

// File: verilog/analog_spindle_mode_gear_select.sv
// Operation
// - Mode flags: mechanical 00, analog 10 (analog,serial), serial 11.
// - Analog flag in analog status byte, three serial flags in serial status byte.
// - Controller gear mode picks gear by comparing speed with per-gear ranges.
// - Controller gear mode outputs speed only after gear select is out.
// - External gear mode uses two-bit gear number; speed for that stage.
// - Scheme bit: 0 external gear, 1 controller-chosen gear.
// - Dual analog spindles only in external gear mode, both geared.
// - In dual control, new speed reaches spindle one only with select bit 0, two with bit 1.
// - Unselected spindle keeps its previous speed.
// - Spindles run different speeds, each with own stop and enable.
// - Source select on spindle one picks external code; spindle two unaffected.
// - Arrangement field selects spindle control arrangement, including dual.
// - Tapping bypasses gear handling on speed output.
// - Gear outputs one-hot, bit 0 gear one through bit 3 gear four.
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "spindle_regs.svh"
module analog_spindle_mode_gear_select
    import spindle_pkg::*;
#(
    parameter int SPEED_W = 16,
    parameter int CODE_W  = 12
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic [7:0]         addr,
    input  wire logic [31:0]        wdata,
    input  wire logic               wr_en,
    input  wire logic               rd_en,
    output logic      [31:0]        rdata,
    input  wire logic               speed_cmd_valid,
    input  wire logic               tapping,
    input  wire logic               gear_number_low,
    input  wire logic               gear_number_high,
    input  wire logic [CODE_W-1:0]  ext_speed_code,
    input  wire spindle_ctl_t       ctl_one,
    input  wire spindle_ctl_t       ctl_two,
    output logic                    analog_mode_flag,
    output logic [2:0]              serial_mode_flags,
    output logic [3:0]              gear_out,
    output logic [CODE_W-1:0]       speed_out_one,
    output logic [CODE_W-1:0]       speed_out_two,
    output logic                    speed_out_valid
);
    // ------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) rst_sync_q <= 2'b00;
        else        rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Reset notes:
    // Assertion of rst_b clears every flop at once, no clock needed
    // Release is seen only after two rising edges of clk
    // Keeps all state leaving reset on the same edge
    // Costs two cycles of dead time after every release
    // Callers must hold requests until the third edge after release
    // Everything below uses rst_n, never the raw pin

    // Pin notes:
    // Gear number, speed code, stop and enable come from another clock
    // Each bit passes two flops before any logic reads it
    // Bits of one word may land one cycle apart while it changes
    // The sequencing side must hold a word steady while it matters
    // Adds two cycles of latency to every pin-driven change

    // Pins from the sequencing side cross in through two flops
    localparam int PIN_W = 2 + CODE_W + 4;
    logic [PIN_W-1:0] pin_s1_q, pin_s2_q, pin_raw;
    assign pin_raw = {gear_number_high, gear_number_low, ext_speed_code,
                      ctl_one.stop, ctl_one.enable, ctl_two.stop, ctl_two.enable};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end
    logic [1:0]        ext_gear;
    logic [CODE_W-1:0] ext_code;
    logic              stop_one, en_one, stop_two, en_two;
    assign ext_gear = pin_s2_q[PIN_W-1 -: 2];
    assign ext_code = pin_s2_q[CODE_W+3:4];
    assign stop_one = pin_s2_q[3];
    assign en_one   = pin_s2_q[2];
    assign stop_two = pin_s2_q[1];
    assign en_two   = pin_s2_q[0];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]         select_ctrl_q, config_q;
    logic [SPEED_W-1:0] gear_max_q [4];
    logic [SPEED_W-1:0] speed_cmd_q;
    logic               scheme_ctrl, src_ext;
    arrangement_t       arrangement;
    assign scheme_ctrl = config_q[`BIT_SCHEME];
    assign arrangement = arrangement_t'(config_q[`BIT_ARR_HI:`BIT_ARR_LO]);
    assign src_ext     = config_q[`BIT_SRC_SEL];

    // Write notes:
    // One write per cycle, taken on the edge with wr_en high
    // Unmapped offsets are dropped without effect
    // Status bytes are read-only; writes to them are ignored
    // Only the low byte of control and config is kept
    // Gear tables keep SPEED_W bits; upper write bits are lost
    // Speed command is stored here and applied by speed_cmd_valid

    // Software writes to control, config and gear tables
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            select_ctrl_q <= `RST_SELECT_CTRL;
            config_q      <= `RST_CONFIG;
            speed_cmd_q   <= '0;
            for (int i = 0; i < 4; i++) gear_max_q[i] <= `RST_GEAR_MAX;
        end else if (wr_en) begin
            case (addr)
                `OFS_SELECT_CTRL: select_ctrl_q <= wdata[7:0];
                `OFS_CONFIG:      config_q      <= wdata[7:0];
                `OFS_GEAR_MAX0:   gear_max_q[0] <= wdata[SPEED_W-1:0];
                `OFS_GEAR_MAX1:   gear_max_q[1] <= wdata[SPEED_W-1:0];
                `OFS_GEAR_MAX2:   gear_max_q[2] <= wdata[SPEED_W-1:0];
                `OFS_GEAR_MAX3:   gear_max_q[3] <= wdata[SPEED_W-1:0];
                `OFS_SPEED_CMD:   speed_cmd_q   <= wdata[SPEED_W-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Mode flags
    // ------------------------------------------------------------
    // Flag notes:
    // Flags follow the arrangement field one cycle later
    // All three serial flags move together; one per spindle slot
    // Dual control counts as analog for the sequencing side
    // Registered so the sequencing side never sees a glitch

    // Analog flag set for analog, serial and dual; serial only for serial
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_mode_flag  <= 1'b0;
            serial_mode_flags <= 3'b000;
        end else begin
            analog_mode_flag  <= (arrangement != ARR_MECHANICAL);
            serial_mode_flags <= {3{arrangement == ARR_SERIAL}};
        end
    end

    // ------------------------------------------------------------
    // Gear selection
    // ------------------------------------------------------------
    // Gear pick notes:
    // Walks the four stages from the top down
    // Last match wins, so the lowest covering stage is chosen
    // A command above every range falls to gear four
    // Gear four then clamps the code at full scale
    // Unused stages must hold zero or they take part in the pick
    // Pure function of registers; no state of its own

    // Lowest gear whose full-scale speed covers the command; zeroed
    // gears never match, so unused stages drop out naturally
    function automatic logic [1:0] pick_gear(input logic [SPEED_W-1:0] s);
        logic [1:0] g;
        g = 2'd3;
        for (int i = 3; i >= 0; i--) begin
            if (gear_max_q[i] != '0 && s <= gear_max_q[i]) g = 2'(i);
        end
        return g;
    endfunction

    function automatic logic [3:0] one_hot(input logic [1:0] g);
        return 4'b0001 << g;
    endfunction

    logic        dual;
    logic [1:0]  ctrl_gear;
    assign dual      = (arrangement == ARR_DUAL) && !scheme_ctrl;
    assign ctrl_gear = pick_gear(speed_cmd_q);

    gear_state_t       gstate_q;
    logic [1:0]        gear_q;
    logic [SPEED_W-1:0] pend_q;
    logic              launch;

    // Handshake notes:
    // Idle waits for a command in the controller scheme
    // Select state: gear output already standing, speed launched
    // Output state: one spare cycle before the next command
    // Commands arriving while busy are ignored, so space them out
    // Tapping commands skip this path entirely
    // Leaving the controller scheme clears the gear outputs

    // Controller-chosen gear: select goes out, speed follows next cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gstate_q <= G_IDLE;
            gear_q   <= 2'd0;
            gear_out <= 4'b0000;
        end else begin
            case (gstate_q)
                G_IDLE: if (speed_cmd_valid && scheme_ctrl && !tapping) begin
                    gear_q   <= ctrl_gear;
                    gear_out <= one_hot(ctrl_gear);
                    gstate_q <= G_SELECT;
                end
                G_SELECT: gstate_q <= G_OUTPUT;
                G_OUTPUT: gstate_q <= G_IDLE;
                default:  gstate_q <= G_IDLE;
            endcase
            if (!scheme_ctrl) gear_out <= 4'b0000;
        end
    end
    assign launch = (gstate_q == G_SELECT);

    // ------------------------------------------------------------
    // Speed scaling and routing
    // ------------------------------------------------------------
    // Scaling notes:
    // Product held at full width so no bits drop before the divide
    // A zero full-scale gives zero rather than a divide fault
    // Result clamps at the top code instead of wrapping
    // Divider is combinational; fine at this scan rate, costly in area
    // Tapping passes the raw speed, clamped the same way

    // Code = speed * 4095 / full-scale; tapping skips gear scaling
    function automatic logic [CODE_W-1:0] scale(input logic [SPEED_W-1:0] s,
                                                 input logic [1:0] g);
        logic [SPEED_W+CODE_W-1:0] num;
        logic [SPEED_W+CODE_W-1:0] q;
        num = SPEED_W'(s) * {CODE_W{1'b1}};
        q   = '0;
        if (tapping) q = (SPEED_W+CODE_W)'(s);
        else if (gear_max_q[g] != '0) q = num / gear_max_q[g];
        if (q > {CODE_W{1'b1}}) q = (SPEED_W+CODE_W)'({CODE_W{1'b1}});
        return q[CODE_W-1:0];
    endfunction

    logic [CODE_W-1:0] code_ext_gear, code_ctrl, hold_one_q, hold_two_q;
    logic              sel_one, sel_two;
    assign code_ext_gear = scale(speed_cmd_q, ext_gear);
    assign code_ctrl     = scale(pend_q, gear_q);
    assign sel_one = select_ctrl_q[`BIT_SPINDLE_ONE] || !dual;
    assign sel_two = select_ctrl_q[`BIT_SPINDLE_TWO] && dual;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pend_q <= '0;
        else if (gstate_q == G_IDLE && speed_cmd_valid) pend_q <= speed_cmd_q;
    end

    // Hold notes:
    // Each spindle keeps its last accepted code
    // External scheme: select bits decide who takes the command
    // Outside dual control spindle one always takes it
    // Controller scheme drives spindle one only
    // Valid pulses once for each accepted command

    // Held commands per spindle; unselected spindle keeps old speed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_one_q      <= `RST_SPEED;
            hold_two_q      <= `RST_SPEED;
            speed_out_valid <= 1'b0;
        end else begin
            speed_out_valid <= 1'b0;
            if (scheme_ctrl) begin
                if (launch) begin
                    hold_one_q      <= code_ctrl;
                    speed_out_valid <= 1'b1;
                end else if (speed_cmd_valid && tapping) begin
                    hold_one_q      <= scale(speed_cmd_q, 2'd0);
                    speed_out_valid <= 1'b1;
                end
            end else if (speed_cmd_valid) begin
                if (sel_one) hold_one_q <= code_ext_gear;
                if (sel_two) hold_two_q <= code_ext_gear;
                speed_out_valid <= sel_one || sel_two;
            end
        end
    end

    // Output notes:
    // Stop or a missing enable forces zero, hold left untouched
    // Restart resumes the held speed without a new command
    // External code bypasses the hold on spindle one only
    // Spindle two is silent outside dual control

    // Outputs with independent stop and enable; external code on one only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_out_one <= `RST_SPEED;
            speed_out_two <= `RST_SPEED;
        end else begin
            speed_out_one <= (stop_one || !en_one) ? `RST_SPEED :
                             (src_ext ? ext_code : hold_one_q);
            speed_out_two <= (stop_two || !en_two || !dual) ? `RST_SPEED :
                             hold_two_q;
        end
    end

    // ------------------------------------------------------------
    // Register read-back, one cycle after the strobe
    // ------------------------------------------------------------
    // Read notes:
    // Data stands only in the cycle after the strobe
    // Zero at all other times, so an OR-ed bus is safe
    // Unmapped offsets read as zero
    // Reads have no side effects

    // Read data, registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) rdata <= '0;
        else if (rd_en) begin
            case (addr)
                `OFS_ANALOG_STATUS: rdata <= 32'(analog_mode_flag);
                `OFS_SERIAL_STATUS: rdata <= 32'(serial_mode_flags);
                `OFS_SELECT_CTRL:   rdata <= 32'(select_ctrl_q);
                `OFS_CONFIG:        rdata <= 32'(config_q);
                `OFS_GEAR_MAX0:     rdata <= 32'(gear_max_q[0]);
                `OFS_GEAR_MAX1:     rdata <= 32'(gear_max_q[1]);
                `OFS_GEAR_MAX2:     rdata <= 32'(gear_max_q[2]);
                `OFS_GEAR_MAX3:     rdata <= 32'(gear_max_q[3]);
                `OFS_SPEED_CMD:     rdata <= 32'(speed_cmd_q);
                `OFS_EXT_CODE:      rdata <= 32'(ext_code);
                `OFS_SPEED_OUT1:    rdata <= 32'(speed_out_one);
                `OFS_SPEED_OUT2:    rdata <= 32'(speed_out_two);
                `OFS_GEAR_STATUS:   rdata <= 32'({gear_q, gear_out});
                default:            rdata <= 32'h0000_0000;
            endcase
        end else rdata <= '0;
    end
endmodule : analog_spindle_mode_gear_select

// File: verif/spindle_checker.sv
`timescale 1ns/1ps
module spindle_checker #(
    parameter int CODE_W = 12
) (
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              rd_en,
    input wire logic [31:0]       rdata,
    input wire logic              speed_cmd_valid,
    input wire logic              analog_mode_flag,
    input wire logic [2:0]        serial_mode_flags,
    input wire logic [3:0]        gear_out,
    input wire logic [CODE_W-1:0] ext_speed_code,
    input wire logic [CODE_W-1:0] speed_out_one,
    input wire logic [CODE_W-1:0] speed_out_two,
    input wire logic              speed_out_valid
);
// ------------------------------------------------------------
// Port relations
// ------------------------------------------------------------
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_b);
a_gear_one_hot: assert property ($onehot0(gear_out))
    else $error("gear outputs not one-hot");
a_serial_implies_analog: assert property (serial_mode_flags != 3'h0 |-> analog_mode_flag)
    else $error("serial mode without analog flag");
a_serial_flags_agree: assert property (serial_mode_flags inside {3'h0, 3'h7})
    else $error("serial flags disagree");
a_valid_has_cause: assert property (speed_out_valid |->
    $past(speed_cmd_valid) || $past(speed_cmd_valid, 2))
    else $error("speed update without command");
// The external code reaches spindle one three edges after the pin moves
a_one_after_valid: assert property (($changed(speed_out_one) && speed_out_one != '0
    && speed_out_one != $past(ext_speed_code, 3))
    |-> $past(speed_out_valid))
    else $error("spindle one speed moved alone");
a_two_after_valid: assert property (($changed(speed_out_two) && speed_out_two != '0)
    |-> $past(speed_out_valid))
    else $error("spindle two speed moved alone");
// Speed may only follow a gear already standing on the outputs
a_gear_before_speed: assert property ((speed_out_valid && gear_out != 4'h0)
    |-> $past(gear_out) == gear_out)
    else $error("speed issued before gear");
a_read_idle_zero: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data outside read slot");
a_reset_quiet: assert property ($rose(rst_b) |->
    gear_out == 4'h0 && !analog_mode_flag ##1 gear_out == 4'h0)
    else $error("outputs active after reset");
endmodule : spindle_checker
bind analog_spindle_mode_gear_select spindle_checker #(.CODE_W(CODE_W)) chk (
    .clk, .rst_b, .rd_en, .rdata, .speed_cmd_valid, .analog_mode_flag, .serial_mode_flags,
    .gear_out, .ext_speed_code, .speed_out_one, .speed_out_two, .speed_out_valid);

// File: verif/plc_model.sv
`timescale 1ns/1ps
module plc_model
    import spindle_pkg::*;
(
    input  wire logic [1:0]  gear_req,
    input  wire logic [11:0] code_req,
    input  wire logic        stop_req,
    output wire logic        gear_number_low,
    output wire logic        gear_number_high,
    output wire logic [11:0] ext_speed_code,
    output wire spindle_ctl_t ctl_one,
    output wire spindle_ctl_t ctl_two
);
// Sequencing side: pins follow the requests, always driven
assign gear_number_low  = gear_req[0];
assign gear_number_high = gear_req[1];
assign ext_speed_code   = code_req;
assign ctl_one          = {stop_req, 1'b1};
assign ctl_two          = {1'b0, 1'b1};
endmodule : plc_model

// File: verif/analog_spindle_mode_gear_select_tb.sv
`timescale 1ns/1ps
`include "spindle_regs.svh"
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value at %0t: %s", $time, m); end end
module analog_spindle_mode_gear_select_tb;
import spindle_pkg::*;
logic clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0, speed_cmd_valid = 1'b0;
logic tapping = 1'b0, stop_req = 1'b0, gl, gh, analog_mode_flag, speed_out_valid;
logic [7:0] addr = 8'h00;
logic [31:0] wdata = 32'h0, rdata;
logic [1:0] gear_req = 2'h0;
logic [11:0] code_req = 12'h000, ext_code, one, two;
logic [2:0] serial_mode_flags;
logic [3:0] gear_out;
spindle_ctl_t ctl_one, ctl_two;
int err_total = 0, n_compared = 0;
int mx[4] = '{1000, 2000, 4000, 5000};
// ------------------------------------------------------------
// Clock, block and far side
// ------------------------------------------------------------
always #5 clk = ~clk;
analog_spindle_mode_gear_select uut (.clk, .rst_b, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .speed_cmd_valid, .tapping, .gear_number_low(gl), .gear_number_high(gh),
    .ext_speed_code(ext_code), .ctl_one, .ctl_two, .analog_mode_flag, .serial_mode_flags,
    .gear_out, .speed_out_one(one), .speed_out_two(two), .speed_out_valid);
plc_model plc (.gear_req, .code_req, .stop_req, .gear_number_low(gl),
    .gear_number_high(gh), .ext_speed_code(ext_code), .ctl_one, .ctl_two);
// ------------------------------------------------------------
// Bus and helpers
// ------------------------------------------------------------
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge clk); wr_en <= 1'b0;
endtask : wr
task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk); addr <= a; rd_en <= 1'b1;
    @(posedge clk); rd_en <= 1'b0;
    #1 d = rdata;
endtask : rd
// Command then wait past the slow controller-gear path
task automatic cmd(input int s);
    wr(`OFS_SPEED_CMD, 32'(s));
    @(posedge clk) speed_cmd_valid <= 1'b1;
    @(posedge clk) speed_cmd_valid <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
endtask : cmd
function automatic logic [11:0] ex(input int s, input int m);
    int v;
    v = s * 4095 / m;
    return (v > 4095) ? 12'hfff : v[11:0];
endfunction : ex
// ------------------------------------------------------------
// Scenarios
// ------------------------------------------------------------
task automatic t_modes;
    logic [31:0] d;
    int cf[3] = '{0, 2, 6};
    for (int i = 0; i < 3; i++) begin
        wr(`OFS_CONFIG, 32'(cf[i]));
        repeat (3) @(posedge clk);
        #1;
        `CHK(analog_mode_flag, 1'(i > 0), "analog flag")
        `CHK(serial_mode_flags, {3{i == 2}}, "serial flags")
        rd(`OFS_ANALOG_STATUS, d);
        `CHK(d[0], 1'(i > 0), "analog status")
        rd(`OFS_SERIAL_STATUS, d);
        `CHK(d[2:0], {3{i == 2}}, "serial status")
    end
endtask : t_modes
task automatic t_ext_gears;
    wr(`OFS_CONFIG, 32'h2);
    for (int g = 0; g < 4; g++) wr(`OFS_GEAR_MAX0 + 8'(4 * g), 32'(mx[g]));
    for (int g = 0; g < 4; g++) begin
        gear_req <= 2'(g);
        cmd(800);
        `CHK(one, ex(800, mx[g]), "external gear speed")
        `CHK(gear_out, 4'h0, "gear outputs in external mode")
    end
    tapping <= 1'b1;
    cmd(800);
    `CHK(one, 12'd800, "tapping speed")
    tapping <= 1'b0;
endtask : t_ext_gears
task automatic t_ctrl;
    int s[3] = '{800, 1500, 6000};
    logic [3:0] g[3] = '{4'h1, 4'h2, 4'h8};
    wr(`OFS_CONFIG, 32'h3);
    for (int i = 0; i < 3; i++) begin
        cmd(s[i]);
        `CHK(gear_out, g[i], "chosen gear")
        `CHK(one, ex(s[i], mx[i == 0 ? 0 : i == 1 ? 1 : 3]), "chosen gear speed")
    end
endtask : t_ctrl
task automatic t_dual;
    wr(`OFS_CONFIG, 32'h4);
    gear_req <= 2'h0;
    wr(`OFS_SELECT_CTRL, 32'h1);
    cmd(800);
    `CHK(one, ex(800, 1000), "spindle one selected")
    wr(`OFS_SELECT_CTRL, 32'h2);
    cmd(400);
    `CHK(two, ex(400, 1000), "spindle two selected")
    `CHK(one, ex(800, 1000), "spindle one held")
    wr(`OFS_SELECT_CTRL, 32'h3);
    cmd(200);
    `CHK(one, ex(200, 1000), "both selected one")
    `CHK(two, ex(200, 1000), "both selected two")
endtask : t_dual
// External code reaches spindle one only; stop then drops it alone
task automatic t_source_stop;
    wr(`OFS_CONFIG, 32'hc);
    code_req <= 12'h5a5;
    cmd(600);
    `CHK(one, 12'h5a5, "external code on one")
    `CHK(two, ex(600, 1000), "computed speed on two")
    stop_req <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    `CHK(one, 12'h000, "stopped spindle")
    `CHK(two, ex(600, 1000), "running spindle")
endtask : t_source_stop
task automatic t_regs;
    logic [31:0] d;
    rd(`OFS_SELECT_CTRL, d);
    `CHK(d[1:0], 2'h3, "select readback")
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h3c, d);
    `CHK(d, 32'h0, "unmapped read")
endtask : t_regs
// ------------------------------------------------------------
// Run control
// ------------------------------------------------------------
task automatic print_verdict;
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask : print_verdict
// Main sequence; first request waits out the internal reset flops
initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_modes();
    t_ext_gears();
    t_ctrl();
    t_dual();
    t_source_stop();
    t_regs();
    print_verdict();
end
// Watchdog well beyond the fewer than two hundred cycles the run needs
initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    print_verdict();
end
endmodule : analog_spindle_mode_gear_select_tb
